// *** verilog/fcpd_pkg.sv ***
// package of constants and carriers for the field colour pixel decoder
package fcpd_pkg;

	// =========================================================
	// geometry
	localparam int          DOTS_PER_FIELD = 8;
	localparam logic [5:0]  FIELDS_LOW     = 6'h09;
	localparam logic [5:0]  FIELDS_MID     = 6'h14;
	localparam logic [5:0]  FIELDS_HIGH    = 6'h2A;
	localparam logic [2:0]  TEXT_LINES     = 3'h4;
	localparam logic [3:0]  PALETTE_RESET  = 4'h0;
	localparam int          BG_LSB         = 0;
	localparam int          FG_LSB         = 4;

	// =========================================================
	// types
	typedef enum logic [1:0] {
		RES_LOW,
		RES_MID,
		RES_HIGH
	} fcpd_res_type;

	typedef struct packed {
		logic [7:0] pattern;
		logic [7:0] colour;
	} fcpd_field_type;

	typedef struct packed {
		logic       valid;
		logic [3:0] colour;
		logic       last_dot;
	} fcpd_dot_type;

	function automatic logic [5:0] fcpd_fields(input fcpd_res_type res);
		case (res)
			RES_LOW:  fcpd_fields = FIELDS_LOW;
			RES_MID:  fcpd_fields = FIELDS_MID;
			default:  fcpd_fields = FIELDS_HIGH;
		endcase
	endfunction : fcpd_fields

endpackage : fcpd_pkg

// *** verilog/fcpd_buffer.sv ***
// two-entry buffer of field words between memory fetch and dot output
`timescale 1ns/100ps
module fcpd_buffer #(
	parameter int WIDTH = 16
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem_q [2];
	logic             wr_q;
	logic             rd_q;
	logic [1:0]       count_q;
	logic             push;
	logic             pop;

	assign push      = in_valid && (count_q != 2'h2);
	assign pop       = out_ready && (count_q != 2'h0);
	assign in_ready  = (count_q != 2'h2);
	assign out_valid = (count_q != 2'h0);
	assign out_data  = mem_q[rd_q];

	always_ff @(posedge clk) begin
		if (reset) begin
			wr_q    <= 1'b0;
			rd_q    <= 1'b0;
			count_q <= 2'h0;
		end else begin
			if (push) begin
				wr_q <= ~wr_q;
			end
			if (pop) begin
				rd_q <= ~rd_q;
			end
			count_q <= count_q + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

endmodule : fcpd_buffer

// *** verilog/fcpd_decoder.sv ***
// field colour pixel decoder: screen bytes in, one colour number per dot out
`timescale 1ns/100ps
module fcpd_decoder (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic                  sixteen_mode,
	input  wire fcpd_pkg::fcpd_res_type resolution,
	input  wire logic                  text_area,
	input  wire logic                  pal_we,
	input  wire logic [1:0]            pal_sel,
	input  wire logic [3:0]            pal_data,
	input  wire logic                  row_start,
	output logic                       mem_req,
	output logic      [5:0]            mem_field,
	output logic                       mem_init,
	output logic      [3:0]            mem_init_bg,
	input  wire logic                  mem_valid,
	input  wire logic [15:0]           mem_data,
	output logic                       dot_valid,
	output logic      [3:0]            dot_colour,
	output logic                       dot_row_end,
	output logic      [2:0]            text_rows,
	input  wire logic                  dot_ready
);
	import fcpd_pkg::*;

	// =========================================================
	// palette of the four-colour mode
	// entry 0 also seeds the sixteen-colour background on mode entry
	logic [3:0] pal_q [4];
	logic       mode_prev_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < 4; i++) begin
				pal_q[i] <= PALETTE_RESET;
			end
		end else if (pal_we) begin
			// stored always; in sixteen-colour mode the palette only steers init
			pal_q[pal_sel] <= pal_data;
		end
	end

	// background seed request on entering sixteen-colour mode
	// memory side fills every background nibble on this pulse
	always_ff @(posedge clk) begin
		if (reset) begin
			mode_prev_q <= 1'b0;
			mem_init    <= 1'b0;
			mem_init_bg <= PALETTE_RESET;
		end else begin
			mode_prev_q <= sixteen_mode;
			mem_init    <= sixteen_mode && !mode_prev_q;
			mem_init_bg <= pal_q[0];
		end
	end

	// text rows reported only; moving the picture is the scan side's job
	always_ff @(posedge clk) begin
		if (reset) begin
			text_rows <= 3'h0;
		end else begin
			text_rows <= text_area ? TEXT_LINES : 3'h0;
		end
	end

	// =========================================================
	// field fetch
	// at most one request is ever in flight, so the two-entry buffer
	// always has a free slot for the answer it is waiting on
	typedef enum logic [1:0] {
		FETCH_IDLE,
		FETCH_ISSUE,
		FETCH_WAIT
	} fcpd_fetch_type;

	fcpd_fetch_type fetch_state_q;
	logic [5:0]     fetch_q;
	logic [5:0]     nfields;
	logic           buf_push;
	logic           buf_in_ready;
	logic           buf_out_valid;
	logic [16:0]    buf_in;
	logic [16:0]    buf_o;
	logic [15:0]    buf_out;
	logic           load;

	// true once the index names the row's final field; at-or-past so
	// a resolution change mid-row cannot let the fetch run away
	function automatic logic last_of_row(input logic [5:0] idx, input logic [5:0] total);
		last_of_row = (idx >= total - 6'h01);
	endfunction : last_of_row

	assign nfields  = fcpd_fields(resolution);
	assign buf_push = (fetch_state_q == FETCH_WAIT) && mem_valid;
	// last-field marker rides with the word
	assign buf_in   = {last_of_row(fetch_q, nfields), mem_data};
	assign buf_out  = buf_o[15:0];

	always_ff @(posedge clk) begin
		if (reset) begin
			fetch_state_q <= FETCH_IDLE;
			fetch_q       <= 6'h00;
			mem_req       <= 1'b0;
			mem_field     <= 6'h00;
		end else begin
			mem_req <= 1'b0;
			case (fetch_state_q)
				FETCH_IDLE: begin
					// a start during a row is ignored, the row runs to its end
					if (row_start) begin
						fetch_state_q <= FETCH_ISSUE;
						fetch_q       <= 6'h00;
					end
				end
				FETCH_ISSUE: begin
					// wait for room so a stalled receiver never loses a word
					if (buf_in_ready) begin
						mem_req       <= 1'b1;
						mem_field     <= fetch_q;
						fetch_state_q <= FETCH_WAIT;
					end
				end
				FETCH_WAIT: begin
					// the word itself is pushed by buf_push at this edge
					if (mem_valid) begin
						fetch_q <= fetch_q + 6'h01;
						if (last_of_row(fetch_q, nfields)) begin
							fetch_state_q <= FETCH_IDLE;
						end else begin
							fetch_state_q <= FETCH_ISSUE;
						end
					end
				end
				default: begin
					fetch_state_q <= FETCH_IDLE;
				end
			endcase
		end
	end

	fcpd_buffer #(
		.WIDTH (17)
	) u_buffer (
		.clk       (clk),
		.reset     (reset),
		.in_valid  (buf_push),
		.in_ready  (buf_in_ready),
		.in_data   (buf_in),
		.out_valid (buf_out_valid),
		.out_ready (load),
		.out_data  (buf_o)
	);

	// =========================================================
	// dot serialiser
	fcpd_field_type field_q;
	logic           last_field_q;
	logic [2:0]     dot_q;
	logic           active_q;
	logic           advance;
	logic           bit_v;
	logic [1:0]     pair_v;
	fcpd_field_type f;
	// index of the rightmost dot of a field
	localparam logic [2:0] LAST_DOT = 3'(DOTS_PER_FIELD - 1);

	// a stalled dot freezes the serialiser and the output stage alike
	assign advance = !dot_valid || dot_ready;
	// a field is loaded whole before its first dot leaves
	assign load    = advance && buf_out_valid && (!active_q || dot_q == LAST_DOT);
	assign f       = buf_out;

	always_ff @(posedge clk) begin
		if (reset) begin
			active_q     <= 1'b0;
			dot_q        <= 3'h0;
			field_q      <= '0;
			last_field_q <= 1'b0;
		end else if (advance) begin
			if (load) begin
				field_q      <= f;
				last_field_q <= buf_o[16];
				active_q     <= 1'b1;
				dot_q        <= 3'h0;
			end else if (active_q) begin
				if (dot_q == LAST_DOT) begin
					active_q <= 1'b0;
				end
				dot_q <= dot_q + 3'h1;
			end
		end
	end

	// pattern bit of a dot; the leftmost dot sits on the msb
	function automatic logic [2:0] bit_pos(input logic [2:0] dot);
		bit_pos = LAST_DOT - dot;
	endfunction : bit_pos

	// colour choice for the dot now in the serialiser
	always_comb begin
		bit_v  = field_q.pattern[bit_pos(dot_q)];
		pair_v = {field_q.pattern[bit_pos(dot_q)], field_q.colour[bit_pos(dot_q)]};
	end

	// output stage: every port here comes straight from a register
	always_ff @(posedge clk) begin
		if (reset) begin
			dot_valid   <= 1'b0;
			dot_colour  <= 4'h0;
			dot_row_end <= 1'b0;
		end else if (advance) begin
			dot_valid   <= active_q;
			dot_row_end <= active_q && last_field_q && dot_q == LAST_DOT;
			if (sixteen_mode) begin
				// only the field's two nibbles can ever appear
				dot_colour <= bit_v ? field_q.colour[FG_LSB +: 4]
				                    : field_q.colour[BG_LSB +: 4];
			end else begin
				dot_colour <= pal_q[pair_v];
			end
		end
	end

endmodule : fcpd_decoder

// *** tb/fcpd_props.sv ***
// port checker for the decoder
`timescale 1ns/100ps
module fcpd_props
	import fcpd_pkg::*;
(
	input wire logic                   clk,
	input wire logic                   reset,
	input wire logic                   sixteen_mode,
	input wire logic                   text_area,
	input wire logic                   mem_req,
	input wire logic [5:0]             mem_field,
	input wire logic                   mem_init,
	input wire logic                   mem_valid,
	input wire logic                   dot_valid,
	input wire logic [3:0]             dot_colour,
	input wire logic                   dot_row_end,
	input wire logic [2:0]             text_rows,
	input wire logic                   dot_ready
);
	// ====
	// helper
	logic [5:0] last_q;
	always_ff @(posedge clk) begin
		if (mem_req) last_q <= mem_field;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	AST_IDLE: assert property ($past(reset) |-> !mem_req && !dot_valid && !mem_init)
		else $error("output busy after reset");
	AST_ONE_REQ: assert property (mem_req |=> !mem_req [*2])
		else $error("second fetch too soon");
	AST_STEP: assert property (mem_req && mem_field != 6'h00 |-> mem_field == last_q + 6'h01)
		else $error("field index skipped");
	AST_INIT: assert property ($rose(sixteen_mode) && !$past(reset) |-> ##[1:2] mem_init)
		else $error("no seed on mode entry");
	AST_INIT_PULSE: assert property (mem_init |=> !mem_init)
		else $error("seed pulse too long");
	AST_HOLD: assert property (dot_valid && !dot_ready |=> dot_valid && $stable(dot_colour))
		else $error("dot changed while stalled");
	AST_END: assert property (dot_row_end |-> dot_valid)
		else $error("row end without dot");
	AST_TEXT: assert property (!$past(reset) |-> text_rows == ($past(text_area) ? TEXT_LINES : 3'h0))
		else $error("text rows wrong");
	COV_INIT: cover property (mem_init);
	COV_STALL: cover property (dot_valid && !dot_ready);
	COV_END: cover property (dot_row_end);
	COV_FOUR: cover property (!sixteen_mode && dot_valid && dot_ready);
endmodule : fcpd_props
bind fcpd_decoder fcpd_props i_props (
	.clk          (clk),
	.reset        (reset),
	.sixteen_mode (sixteen_mode),
	.text_area    (text_area),
	.mem_req      (mem_req),
	.mem_field    (mem_field),
	.mem_init     (mem_init),
	.mem_valid    (mem_valid),
	.dot_valid    (dot_valid),
	.dot_colour   (dot_colour),
	.dot_row_end  (dot_row_end),
	.text_rows    (text_rows),
	.dot_ready    (dot_ready)
);

// *** tb/fcpd_mem_model.sv ***
// screen memory model answering field fetches
`timescale 1ns/100ps
module fcpd_mem_model
	import fcpd_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        slow,
	input  wire logic        mem_req,
	input  wire logic [5:0]  mem_field,
	input  wire logic        mem_init,
	input  wire logic [3:0]  mem_init_bg,
	output logic             mem_valid,
	output logic      [15:0] mem_data
);
	// ====
	// one fetch at a time
	logic [3:0]  wait_q;
	logic [5:0]  fld_q;
	logic [3:0]  bg_q;
	logic [15:0] word;
	always_ff @(posedge clk) begin
		if (reset) wait_q <= 4'h0;
		else if (mem_req) wait_q <= slow ? 4'h6 : 4'h2;
		else if (wait_q != 4'h0) wait_q <= wait_q - 4'h1;
		if (mem_req) fld_q <= mem_field;
	end
	always_ff @(posedge clk) begin
		if (reset) bg_q <= 4'h0;
		else if (mem_init) bg_q <= mem_init_bg;
	end
	// fg follows the low four bits of the field index and pattern the whole index, so every field differs
	assign word = {8'hA5 ^ {fld_q, 2'b00}, fld_q[3:0], bg_q};
	assign mem_valid = (wait_q == 4'h1);
	// inverse between answers, never a stale word
	assign mem_data = mem_valid ? word : ~word;
endmodule : fcpd_mem_model

// *** tb/test_fcpd_decoder.sv ***
// bench for the field colour decoder
`timescale 1ns/100ps
module test_fcpd_decoder;
	import fcpd_pkg::*;
	logic clk, reset, sixteen_mode, text_area, pal_we, row_start, dot_ready, slow;
	logic mem_req, mem_init, mem_valid, dot_valid, dot_row_end;
	logic [1:0]   pal_sel;
	logic [2:0]   text_rows;
	logic [3:0]   pal_data, mem_init_bg, dot_colour;
	logic [5:0]   mem_field;
	logic [15:0]  mem_data;
	fcpd_res_type resolution;
	int           failures;
	int           check_count;
	// background seeded from palette entry 0 on sixteen-colour entry
	localparam logic [3:0] SEED_BG = 4'h9;
	fcpd_decoder i_dut (
		.clk          (clk),
		.reset        (reset),
		.sixteen_mode (sixteen_mode),
		.resolution   (resolution),
		.text_area    (text_area),
		.pal_we       (pal_we),
		.pal_sel      (pal_sel),
		.pal_data     (pal_data),
		.row_start    (row_start),
		.mem_req      (mem_req),
		.mem_field    (mem_field),
		.mem_init     (mem_init),
		.mem_init_bg  (mem_init_bg),
		.mem_valid    (mem_valid),
		.mem_data     (mem_data),
		.dot_valid    (dot_valid),
		.dot_colour   (dot_colour),
		.dot_row_end  (dot_row_end),
		.text_rows    (text_rows),
		.dot_ready    (dot_ready)
	);
	fcpd_mem_model i_mem (
		.clk         (clk),
		.reset       (reset),
		.slow        (slow),
		.mem_req     (mem_req),
		.mem_field   (mem_field),
		.mem_init    (mem_init),
		.mem_init_bg (mem_init_bg),
		.mem_valid   (mem_valid),
		.mem_data    (mem_data)
	);
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		check_count++;
		if (s !== e) begin
			failures++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask : chk
	task automatic print_verdict;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict
	task automatic t_text(input logic on);
		text_area <= on;
		repeat (3) @(posedge clk);
		chk("rows", on ? 16'(TEXT_LINES) : 16'h0000, 16'(text_rows));
	endtask : t_text
	// palette write at row start must not show in the dots
	task automatic t_row(input fcpd_res_type r, input int n, input logic st);
		int         k;
		int         t;
		logic [7:0] p;
		k = 0;
		t = 0;
		resolution <= r;
		slow <= st;
		row_start <= 1'b1;
		pal_we <= 1'b1;
		pal_data <= 4'h3;
		@(posedge clk);
		row_start <= 1'b0;
		pal_we <= 1'b0;
		while (k < n * 8 && t < 4000) begin
			@(posedge clk);
			t++;
			dot_ready <= !st || t[1];
			if (dot_valid === 1'b1 && dot_ready) begin
				p = 8'hA5 ^ {k[8:3], 2'b00};
				chk("dot", 16'(p[7 - k % 8] ? k[6:3] : SEED_BG), 16'(dot_colour));
				chk("end", 16'(k == n * 8 - 1), 16'(dot_row_end));
				k++;
			end
		end
		chk("count", 16'(n * 8), 16'(k));
	endtask : t_row
	// four-colour row: each dot shows the palette entry its bit pair picks
	task automatic t_four(input int n);
		int         k;
		int         t;
		logic [7:0] p;
		logic [7:0] c;
		logic [1:0] idx;
		logic [3:0] pal [4];
		k = 0;
		t = 0;
		pal = '{4'h2, 4'h6, 4'hB, 4'hE};
		sixteen_mode <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			pal_we <= 1'b1;
			pal_sel <= 2'(i);
			pal_data <= pal[i];
			@(posedge clk);
		end
		pal_we <= 1'b0;
		resolution <= RES_LOW;
		slow <= 1'b0;
		dot_ready <= 1'b1;
		row_start <= 1'b1;
		@(posedge clk);
		row_start <= 1'b0;
		while (k < n * 8 && t < 4000) begin
			@(posedge clk);
			t++;
			if (dot_valid === 1'b1) begin
				p = 8'hA5 ^ {k[8:3], 2'b00};
				c = {k[6:3], SEED_BG};
				idx = {p[7 - k % 8], c[7 - k % 8]};
				chk("four", 16'(pal[idx]), 16'(dot_colour));
				chk("end", 16'(k == n * 8 - 1), 16'(dot_row_end));
				k++;
			end
		end
		chk("count", 16'(n * 8), 16'(k));
	endtask : t_four
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#400000;
		failures++;
		print_verdict();
	end
	initial begin
		{reset, dot_ready} = 2'h3;
		{sixteen_mode, text_area, pal_we, row_start, slow} = 5'h00;
		{pal_sel, pal_data} = 6'h00;
		resolution = RES_LOW;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		pal_we <= 1'b1;
		pal_data <= 4'h9;
		@(posedge clk);
		pal_we <= 1'b0;
		sixteen_mode <= 1'b1;
		t_text(1'b1);
		t_row(RES_LOW, 9, 1'b0);
		t_row(RES_MID, 20, 1'b1);
		t_row(RES_HIGH, 42, 1'b0);
		t_text(1'b0);
		t_four(9);
		print_verdict();
	end
endmodule : test_fcpd_decoder
